// [verilog/cfg_handshake_cfg.svh]
// Constants for the configuration status and chaining handshake
//==============================================================
// Functional notes
//==============================================================
`ifndef CFG_HANDSHAKE_CFG_SVH
`define CFG_HANDSHAKE_CFG_SVH

//==============================================================
// Timing and data length
//==============================================================
`define CFG_CLK_PERIOD_NS     10
`define CFG_POR_TIME_NS       100000
`define CFG_POR_CYCLES        (`CFG_POR_TIME_NS / `CFG_CLK_PERIOD_NS)
`define CFG_INIT_CYCLES       16
`define CFG_DATA_WORDS        32

`endif

// [verilog/cfg_handshake_pkg.sv]
// Types shared by both ends of the configuration handshake
package cfg_handshake_pkg;

   //==============================================================
   // Device sequencer states
   //==============================================================
   typedef enum logic [2:0] {
      ST_POR     = 3'b000,
      ST_RESET   = 3'b001,
      ST_LOAD    = 3'b010,
      ST_WAITCD  = 3'b011,
      ST_INIT    = 3'b100,
      ST_USER    = 3'b101,
      ST_ERROR   = 3'b110
   } dev_state_t;

   //==============================================================
   // Controller states
   //==============================================================
   typedef enum logic [2:0] {
      CT_IDLE    = 3'b000,
      CT_PULSE   = 3'b001,
      CT_WAITST  = 3'b010,
      CT_SEND    = 3'b011,
      CT_WAITCD  = 3'b100,
      CT_DONE    = 3'b101,
      CT_FAIL    = 3'b110
   } ctl_state_t;

endpackage : cfg_handshake_pkg

// [verilog/cfg_link_if.sv]
// Pin bundle between the configurable device and its controller
`timescale 1ns/1ps
interface cfg_link_if;
   // Device side drives
   logic status_oe_dev;
   logic complete_oe_dev;
   logic chain_enable_out_n;
   // Controller side drives
   logic status_oe_ctl;
   logic complete_oe_ctl;
   logic reconfig_request_n;
   logic chip_enable_in_n;
   logic data_valid;
   logic data_error;
   // Resolved wired-AND levels, pulled up when nobody drives
   logic cfg_status_line_n;
   logic cfg_complete_line;

   assign cfg_status_line_n = !(status_oe_dev || status_oe_ctl);
   assign cfg_complete_line = !(complete_oe_dev || complete_oe_ctl);

   modport device (
      output status_oe_dev, complete_oe_dev, chain_enable_out_n,
      input  cfg_status_line_n, cfg_complete_line, reconfig_request_n,
      input  chip_enable_in_n, data_valid, data_error
   );
   modport ctl (
      output status_oe_ctl, complete_oe_ctl, reconfig_request_n,
      output chip_enable_in_n, data_valid, data_error,
      input  cfg_status_line_n, cfg_complete_line
   );
endinterface : cfg_link_if

// [verilog/cfg_device_end.sv]
// Device-side configuration sequencer for status and chaining pins
`timescale 1ns/1ps
`include "cfg_handshake_cfg.svh"
module cfg_device_end #(
   parameter int POR_CYCLES  = `CFG_POR_CYCLES,
   parameter int INIT_CYCLES = `CFG_INIT_CYCLES,
   parameter int DATA_WORDS  = `CFG_DATA_WORDS
) (
   // Clock and reset
   input  wire logic   CLK_SYS,
   input  wire logic   RST,
   // Link pins
   cfg_link_if.device  LINK,
   // User side
   output logic        USER_MODE,
   output logic        CFG_ERROR,
   output logic        USER_PINS_FLOAT
);
   if (POR_CYCLES < 1 || INIT_CYCLES < 1 || DATA_WORDS < 1) begin : g_bad_cnt
      $error("cfg_device_end: counts must be at least one");
   end

   localparam int CW = $clog2(POR_CYCLES + INIT_CYCLES + DATA_WORDS + 2);

   //==============================================================
   // Pin synchronisers
   //==============================================================
   logic [4:0] s1_r;
   logic [4:0] s2_r;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         s1_r <= 5'h1f;
         s2_r <= 5'h1f;
      end else begin
         s1_r <= {LINK.cfg_status_line_n, LINK.cfg_complete_line,
                  LINK.reconfig_request_n, LINK.chip_enable_in_n,
                  !LINK.data_error};
         s2_r <= s1_r;
      end
   end
   logic status_n, complete, reconf_n, ce_n, err_n;
   assign {status_n, complete, reconf_n, ce_n, err_n} = s2_r;

   // Data strobe is same-clock logic from the controller
   logic data_valid;
   assign data_valid = LINK.data_valid;

   // Own pull returns through the synchroniser two edges late; it
   // must not be taken for an outside party pulling status low
   logic status_oe_r, complete_oe_r, chain_n_r;
   logic own_d1_r;
   logic own_d2_r;
   logic ext_low;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         own_d1_r <= 1'b1;
         own_d2_r <= 1'b1;
      end else begin
         own_d1_r <= status_oe_r;
         own_d2_r <= own_d1_r;
      end
   end
   assign ext_low = !status_n && !own_d2_r;

   //==============================================================
   // Sequencer
   //==============================================================
   cfg_handshake_pkg::dev_state_t state_r;
   cfg_handshake_pkg::dev_state_t state_nxt;
   logic [CW-1:0] cnt_r;
   logic          last;
   assign last = (cnt_r == CW'(0));

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         cfg_handshake_pkg::ST_POR:
            if (last) state_nxt = cfg_handshake_pkg::ST_RESET;
         cfg_handshake_pkg::ST_RESET:
            if (reconf_n && !ce_n)
               state_nxt = cfg_handshake_pkg::ST_LOAD;
         cfg_handshake_pkg::ST_LOAD:
            if (!err_n || ext_low)
               state_nxt = cfg_handshake_pkg::ST_ERROR;
            else if (data_valid && last)
               state_nxt = cfg_handshake_pkg::ST_WAITCD;
         cfg_handshake_pkg::ST_WAITCD:
            if (ext_low)
               state_nxt = cfg_handshake_pkg::ST_ERROR;
            else if (complete)
               state_nxt = cfg_handshake_pkg::ST_INIT;
         cfg_handshake_pkg::ST_INIT:
            if (ext_low)
               state_nxt = cfg_handshake_pkg::ST_ERROR;
            else if (last)
               state_nxt = cfg_handshake_pkg::ST_USER;
         cfg_handshake_pkg::ST_USER:
            // Status and completion lines not looked at here
            state_nxt = cfg_handshake_pkg::ST_USER;
         cfg_handshake_pkg::ST_ERROR:
            state_nxt = cfg_handshake_pkg::ST_ERROR;
         default:
            state_nxt = cfg_handshake_pkg::ST_POR;
      endcase
      // Reconfig request overrides everything after power-on
      if (!reconf_n && state_r != cfg_handshake_pkg::ST_POR)
         state_nxt = cfg_handshake_pkg::ST_RESET;
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST)
         state_r <= cfg_handshake_pkg::ST_POR;
      else
         state_r <= state_nxt;
   end

   // One counter serves power-on, data words and init cycles
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST)
         cnt_r <= CW'(POR_CYCLES - 1);
      else if (state_nxt != state_r) begin
         case (state_nxt)
            cfg_handshake_pkg::ST_LOAD: cnt_r <= CW'(DATA_WORDS - 1);
            cfg_handshake_pkg::ST_INIT: cnt_r <= CW'(INIT_CYCLES - 1);
            default:                    cnt_r <= CW'(0);
         endcase
      end else if (!last && (state_r != cfg_handshake_pkg::ST_LOAD
                             || data_valid))
         cnt_r <= cnt_r - CW'(1);
   end

   //==============================================================
   // Pin drivers, registered
   //==============================================================
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         status_oe_r   <= 1'b1;
         complete_oe_r <= 1'b1;
         chain_n_r     <= 1'b1;
      end else begin
         status_oe_r   <= (state_nxt == cfg_handshake_pkg::ST_POR) ||
                          (state_nxt == cfg_handshake_pkg::ST_RESET) ||
                          (state_nxt == cfg_handshake_pkg::ST_ERROR);
         // Released once the last word is in with no error
         complete_oe_r <= (state_nxt != cfg_handshake_pkg::ST_WAITCD) &&
                          (state_nxt != cfg_handshake_pkg::ST_INIT) &&
                          (state_nxt != cfg_handshake_pkg::ST_USER);
         chain_n_r     <= (state_nxt != cfg_handshake_pkg::ST_USER);
      end
   end
   assign LINK.status_oe_dev      = status_oe_r;
   assign LINK.complete_oe_dev    = complete_oe_r;
   // Driven low only in user mode; held high in every other state
   assign LINK.chain_enable_out_n = chain_n_r;

   //==============================================================
   // User-side status
   //==============================================================
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         USER_MODE       <= 1'b0;
         CFG_ERROR       <= 1'b0;
         USER_PINS_FLOAT <= 1'b1;
      end else begin
         USER_MODE       <= (state_nxt == cfg_handshake_pkg::ST_USER);
         CFG_ERROR       <= (state_nxt == cfg_handshake_pkg::ST_ERROR);
         USER_PINS_FLOAT <= (state_nxt != cfg_handshake_pkg::ST_USER);
      end
   end

endmodule : cfg_device_end

// [verilog/cfg_controller_end.sv]
// External configuration controller end of the handshake
`timescale 1ns/1ps
`include "cfg_handshake_cfg.svh"
module cfg_controller_end #(
   parameter int DATA_WORDS = `CFG_DATA_WORDS
) (
   // Clock and reset
   input  wire logic   CLK_SYS,
   input  wire logic   RST,
   // Link pins
   cfg_link_if.ctl     LINK,
   // User side
   input  wire logic   START,
   input  wire logic   ENABLE_N,
   input  wire logic   INJECT_ERROR,
   output logic        BUSY,
   output logic        DONE,
   output logic        FAIL
);
   if (DATA_WORDS < 1) begin : g_bad_words
      $error("cfg_controller_end: DATA_WORDS must be at least one");
   end

   localparam int CW = $clog2(DATA_WORDS + 1);

   //==============================================================
   // Pin synchronisers
   //==============================================================
   logic [1:0] s1_r;
   logic [1:0] s2_r;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         s1_r <= 2'h0;
         s2_r <= 2'h0;
      end else begin
         s1_r <= {LINK.cfg_status_line_n, LINK.cfg_complete_line};
         s2_r <= s1_r;
      end
   end

   cfg_handshake_pkg::ctl_state_t state_r;
   logic [CW-1:0] cnt_r;
   logic          reconf_n_r, valid_r, err_r, ce_n_r;

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         state_r    <= cfg_handshake_pkg::CT_IDLE;
         cnt_r      <= CW'(0);
         reconf_n_r <= 1'b1;
         valid_r    <= 1'b0;
         err_r      <= 1'b0;
      end else begin
         valid_r <= 1'b0;
         err_r   <= 1'b0;
         case (state_r)
            cfg_handshake_pkg::CT_IDLE,
            cfg_handshake_pkg::CT_DONE,
            cfg_handshake_pkg::CT_FAIL:
               if (START) begin
                  // Reconfigure by request line, never status line
                  reconf_n_r <= 1'b0;
                  state_r    <= cfg_handshake_pkg::CT_PULSE;
               end
            cfg_handshake_pkg::CT_PULSE:
               // Hold the request until status reads low, so a stale
               // high status is never taken for the device's release
               if (!s2_r[1]) begin
                  reconf_n_r <= 1'b1;
                  state_r    <= cfg_handshake_pkg::CT_WAITST;
               end
            cfg_handshake_pkg::CT_WAITST:
               if (s2_r[1]) begin
                  cnt_r   <= CW'(DATA_WORDS);
                  state_r <= cfg_handshake_pkg::CT_SEND;
               end
            cfg_handshake_pkg::CT_SEND:
               if (!s2_r[1])
                  state_r <= cfg_handshake_pkg::CT_FAIL;
               else if (INJECT_ERROR)
                  err_r <= 1'b1;
               else if (cnt_r != CW'(0)) begin
                  valid_r <= 1'b1;
                  cnt_r   <= cnt_r - CW'(1);
               end else
                  state_r <= cfg_handshake_pkg::CT_WAITCD;
            cfg_handshake_pkg::CT_WAITCD:
               if (!s2_r[1])
                  state_r <= cfg_handshake_pkg::CT_FAIL;
               else if (s2_r[0])
                  state_r <= cfg_handshake_pkg::CT_DONE;
            default:
               state_r <= cfg_handshake_pkg::CT_IDLE;
         endcase
      end
   end

   // Chip enable held low through every phase when enabled
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST)
         ce_n_r <= 1'b1;
      else
         ce_n_r <= ENABLE_N;
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         BUSY <= 1'b0;
         DONE <= 1'b0;
         FAIL <= 1'b0;
      end else begin
         BUSY <= (state_r == cfg_handshake_pkg::CT_PULSE) ||
                 (state_r == cfg_handshake_pkg::CT_WAITST) ||
                 (state_r == cfg_handshake_pkg::CT_SEND) ||
                 (state_r == cfg_handshake_pkg::CT_WAITCD);
         DONE <= (state_r == cfg_handshake_pkg::CT_DONE);
         FAIL <= (state_r == cfg_handshake_pkg::CT_FAIL);
      end
   end

   // Controller only releases the open-drain lines
   assign LINK.status_oe_ctl      = 1'b0;
   assign LINK.complete_oe_ctl    = 1'b0;
   assign LINK.reconfig_request_n = reconf_n_r;
   assign LINK.chip_enable_in_n   = ce_n_r;
   assign LINK.data_valid         = valid_r;
   assign LINK.data_error         = err_r;

endmodule : cfg_controller_end

// [dv/cfg_link_assertions.sv]
// Checker for the pins between device and controller
`timescale 1ns/1ps
module cfg_link_assertions (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // Link signals
   input wire logic status_oe_dev,
   input wire logic complete_oe_dev,
   input wire logic chain_enable_out_n,
   input wire logic reconfig_request_n,
   input wire logic chip_enable_in_n,
   input wire logic data_valid,
   input wire logic data_error,
   input wire logic cfg_complete_line
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   a_por_status_hold: assert property (
      $fell(RST) |-> status_oe_dev [*8])
      else $error("status released during power-on hold");
   a_release_cause: assert property (
      $fell(status_oe_dev) |->
      $past(reconfig_request_n) && !$past(chip_enable_in_n))
      else $error("status released without enable");
   a_complete_low: assert property (
      data_valid || $fell(status_oe_dev) |-> complete_oe_dev)
      else $error("completion released during transfer");
   a_complete_release: assert property (
      $fell(complete_oe_dev) |-> $past(data_valid))
      else $error("completion released without last word");
   a_error_reported: assert property (
      data_error |-> ##[1:6] status_oe_dev)
      else $error("data fault not reported on status");
   a_ce_blocks: assert property (
      chip_enable_in_n [*5] |-> status_oe_dev && chain_enable_out_n)
      else $error("device configuring while disabled");
   a_chain_on_done: assert property (
      $fell(chain_enable_out_n) |-> !status_oe_dev && !complete_oe_dev)
      else $error("chain enabled before completion");
   a_init_waits_line: assert property (
      $fell(chain_enable_out_n) |->
      $past(cfg_complete_line, 8) && $past(cfg_complete_line, 16))
      else $error("user mode without completion high");
   a_user_mode_holds: assert property (
      $rose(chain_enable_out_n) |-> !$past(reconfig_request_n, 2) ||
      !$past(reconfig_request_n, 3) || !$past(reconfig_request_n, 4) ||
      !$past(reconfig_request_n, 5))
      else $error("user mode left without reconfig request");
endmodule : cfg_link_assertions

// [dv/config_status_handshake_test.sv]
// Self-checking bench for the configuration handshake
`timescale 1ns/1ps
module config_status_handshake_test;
   // ==========
   // Setup
   // ==========
   localparam int POR   = 20;
   localparam int WORDS = 8;
   logic clk_sys, rst, start, enable_n, inject_error;
   logic busy, done, fail, user_mode, cfg_error, pins_float;
   logic user2, error2, float2, inj;
   int   mismatches, checked, n;
   int   cycles = 0;
   cfg_link_if link ();
   cfg_link_if link2 ();

   cfg_device_end #(.POR_CYCLES(POR), .DATA_WORDS(WORDS))
      cfg_device_end_inst (.CLK_SYS(clk_sys), .RST(rst), .LINK(link),
      .USER_MODE(user_mode), .CFG_ERROR(cfg_error),
      .USER_PINS_FLOAT(pins_float));
   cfg_controller_end #(.DATA_WORDS(WORDS)) cfg_controller_end_inst (
      .CLK_SYS(clk_sys), .RST(rst), .LINK(link), .START(start),
      .ENABLE_N(enable_n), .INJECT_ERROR(inject_error), .BUSY(busy),
      .DONE(done), .FAIL(fail));
   // Second device faces the bench, which breaks the far-side rules
   cfg_device_end #(.POR_CYCLES(POR), .DATA_WORDS(WORDS))
      cfg_device_end_inst2 (.CLK_SYS(clk_sys), .RST(rst), .LINK(link2),
      .USER_MODE(user2), .CFG_ERROR(error2), .USER_PINS_FLOAT(float2));
   cfg_link_assertions cfg_link_assertions_inst (.CLK_SYS(clk_sys),
      .RST(rst), .status_oe_dev(link.status_oe_dev),
      .complete_oe_dev(link.complete_oe_dev),
      .chain_enable_out_n(link.chain_enable_out_n),
      .reconfig_request_n(link.reconfig_request_n),
      .chip_enable_in_n(link.chip_enable_in_n),
      .data_valid(link.data_valid), .data_error(link.data_error),
      .cfg_complete_line(link.cfg_complete_line));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ==========
   // Tasks
   // ==========
   function automatic logic exp_ok(input logic err);
      return !err;
   endfunction : exp_ok

   task automatic check(input logic seen, input logic exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic run_ctl(input logic err);
      int k;
      inject_error = err;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      // Busy is registered from the state, so it shows one edge late
      @(negedge clk_sys);
      k = 0;
      while ((busy === 1'b1 || (user_mode !== 1'b1 && cfg_error !== 1'b1))
             && k < 240) begin
         @(negedge clk_sys);
         k++;
      end
      if (k >= 240) mismatches++;
      check(busy, 1'b0);
      check(pins_float, !exp_ok(err));
      check(done, exp_ok(err));
      check(fail, !exp_ok(err));
      check(user_mode, exp_ok(err));
      check(link.chain_enable_out_n, !exp_ok(err));
      check(cfg_error, !exp_ok(err));
      check(link.cfg_complete_line, exp_ok(err));
   endtask : run_ctl

   task automatic send2(input int words);
      link2.data_valid = 1'b1;
      repeat (words) @(negedge clk_sys);
      link2.data_valid = 1'b0;
   endtask : send2

   // ==========
   // Sequence
   // ==========
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end

   initial begin
      rst = 1'b1;
      start = 1'b0;
      enable_n = 1'b1;
      inject_error = 1'b0;
      mismatches = 0;
      checked = 0;
      link2.status_oe_ctl = 1'b0;
      link2.complete_oe_ctl = 1'b0;
      link2.reconfig_request_n = 1'b1;
      link2.chip_enable_in_n = 1'b0;
      link2.data_valid = 1'b0;
      link2.data_error = 1'b0;
      n = $urandom(32'ha30d186a);
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      repeat (POR - 1) @(negedge clk_sys);
      check(link2.cfg_status_line_n, 1'b0);
      repeat (9) @(negedge clk_sys);
      check(link2.cfg_status_line_n, 1'b1);
      check(link.cfg_status_line_n, 1'b0);
      enable_n = 1'b0;
      repeat (8) @(negedge clk_sys);
      check(link.cfg_status_line_n, 1'b1);
      run_ctl(1'b0);
      run_ctl(1'b1);
      for (int i = 0; i < 8; i++) begin
         inj = 1'($urandom_range(0, 1));
         repeat ($urandom_range(1, 6)) @(negedge clk_sys);
         run_ctl(inj);
      end
      check(link2.cfg_complete_line, 1'b0);
      send2(WORDS);
      n = 0;
      while (user2 !== 1'b1 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 60) mismatches++;
      check(user2, 1'b1);
      check(link2.chain_enable_out_n, 1'b0);
      // Outside pulls on both lines must not disturb user mode
      link2.status_oe_ctl = 1'b1;
      link2.complete_oe_ctl = 1'b1;
      repeat (10) @(negedge clk_sys);
      check(user2, 1'b1);
      check(float2, 1'b0);
      link2.status_oe_ctl = 1'b0;
      link2.complete_oe_ctl = 1'b0;
      link2.reconfig_request_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      check(float2, 1'b1);
      check(user2, 1'b0);
      link2.reconfig_request_n = 1'b1;
      repeat (8) @(negedge clk_sys);
      check(link2.cfg_status_line_n, 1'b1);
      send2(WORDS / 2);
      link2.status_oe_ctl = 1'b1;
      repeat (6) @(negedge clk_sys);
      link2.status_oe_ctl = 1'b0;
      repeat (2) @(negedge clk_sys);
      check(error2, 1'b1);
      check(link2.cfg_status_line_n, 1'b0);
      complete_run();
   end
endmodule : config_status_handshake_test
